// ---- hw/dcw_defines.vh ----
// Constants for the drive command word interpreter.
// Included by the design files; holds definitions only.
`ifndef DCW_DEFINES_VH
`define DCW_DEFINES_VH
// Command word bit positions
`define DCW_BIT_SWITCH_ON 0
`define DCW_BIT_ENABLE_VOLTAGE 1
`define DCW_BIT_QUICK_STOP 2
`define DCW_BIT_ENABLE_OP 3
`define DCW_BIT_FAULT_RESET 7
`define DCW_BIT_HALT 8
`define DCW_BIT_DIRECTION 11
`define DCW_ASSIGN_LSB 11
`define DCW_ASSIGN_MSB 15
`define DCW_CMD_RESET 16'h0000
// Operating states
`define DCW_ST_NOT_READY 4'h1
`define DCW_ST_SW_ON_DIS 4'h2
`define DCW_ST_READY 4'h3
`define DCW_ST_SWITCHED_ON 4'h4
`define DCW_ST_OP_ENABLED 4'h5
`define DCW_ST_QSTOP 4'h6
`define DCW_ST_FAULT_REACT 4'h7
`define DCW_ST_FAULT 4'h8
// Masked state word codes
`define DCW_SW_NOT_READY 16'h0000
`define DCW_SW_SW_ON_DIS 16'h0040
`define DCW_SW_READY 16'h0021
`define DCW_SW_SWITCHED_ON 16'h0023
`define DCW_SW_OP_ENABLED 16'h0027
`define DCW_SW_QSTOP 16'h0007
`define DCW_SW_FAULT_REACT 16'h000F
`define DCW_SW_FAULT 16'h0008
`define DCW_SW_VOLTAGE_BIT 4
`define DCW_SW_WARNING_BIT 7
`define DCW_SW_REMOTE_BIT 9
`define DCW_SW_TARGET_BIT 10
// Function source codes: 0 none, 1..5 command word bit 11..15
`define DCW_SRC_NONE 3'h0
`define DCW_SRC_BIT11 3'h1
`define DCW_SRC_BIT15 3'h5
// Halt stop types
`define DCW_STOP_RAMP 2'h0
`define DCW_STOP_FAST 2'h1
`define DCW_STOP_FREEWHEEL 2'h2
`define DCW_STOP_DC_INJ 2'h3
`endif

// ---- hw/dcw_bit_select.v ----
// One function input picked from the assignable command word bits.
// Source code 0 or out of range gives the fallback input value.
`timescale 1ns/1ps
`include "dcw_defines.vh"
module dcw_bit_select (
  // Selection
  input wire [2:0] src_sel,
  input wire [4:0] assign_bits,
  input wire fallback,
  // Result
  output reg func_out
);
  always @* begin
    if (src_sel >= `DCW_SRC_BIT11 && src_sel <= `DCW_SRC_BIT15) begin
      func_out = assign_bits[src_sel - 3'h1];
    end else begin
      func_out = fallback;
    end
  end
endmodule

// ---- hw/dcw_interpreter.v ----
// Drive command word interpreter and drive state machine.
// Assumes the master writes the command word with cmd_we; all inputs synchronous to core_clk.
// Summary of operation
// [R01] Halt in operation enabled stops motion by the stop type without leaving the state.
// [R02] While halt is active in operation enabled, motor power and torque are off.
// [R03] The state stays 5 during halt for every stop type.
// [R04] A fast stop request from terminal or an assigned bit moves to switched on.
// [R05] A freewheel request from terminal or an assigned bit moves to switch on disabled.
// [R06] Command word bits 11 to 15 are selectable sources for function inputs.
// [R07] With reset configuration bit 11 drives direction, 0 forward and 1 reverse.
// [R08] Fault reset acts on a rising edge of bit 7 and only once the fault cause is gone.
// [R09] Bits that are of no significance for a command are ignored in its decode.
// [R10] In fault reaction, supply need and motor energising follow the error response setting.
// [R11] The master encodes shutdown, switch on, enable, disable, disable voltage and quick stop codes.
// [R12] Bits 4, 5, 6, 9 and 10 are reserved and ignored.
// [R13] Disable operation freewheels or ramps to switched on, picked by a one-bit setting.
// [R14] The master may mask the state word with 006F and compare with state codes.
`timescale 1ns/1ps
`include "dcw_defines.vh"
module dcw_interpreter (
  // Clock and reset
  input wire core_clk,
  input wire rst_n,
  // Command word write port
  input wire cmd_we,
  input wire [15:0] cmd_wdata,
  output wire [15:0] cmd_rdata,
  // Configuration
  input wire [1:0] stop_type,
  input wire disable_op_ramp,
  input wire quick_stop_behaviour_select,
  input wire err_resp_supply,
  input wire err_resp_energise,
  input wire [2:0] dir_src,
  input wire [2:0] fast_stop_src,
  input wire [2:0] freewheel_src,
  input wire [2:0] dc_inj_src,
  // Drive-side inputs
  input wire term_fast_stop,
  input wire term_freewheel,
  input wire term_dir,
  input wire power_ready,
  input wire fault_detect,
  input wire fault_active,
  input wire fault_react_done,
  input wire ramp_done,
  input wire supply_present,
  // Drive-side outputs
  output reg [3:0] op_state_reg,
  output wire [15:0] drive_state_word,
  output reg motor_energised_reg,
  output reg supply_required_reg,
  output reg dir_reverse_reg,
  output reg dc_inj_req_reg,
  output reg [1:0] halt_stop_mode_reg,
  output reg halt_active_reg,
  output reg ramp_active_reg,
  output reg freewheel_active_reg
);
  reg [15:0] drive_command_word_reg;
  reg fault_reset_prev_reg;
  reg [3:0] op_state_next;
  reg stopping_reg;
  reg stopping_next;
  reg [15:0] sw_code;
  wire cmd_so;
  wire cmd_ev;
  wire cmd_qs;
  wire cmd_eo;
  wire fault_reset_edge;
  wire sel_dir;
  wire sel_fast;
  wire sel_free;
  wire sel_dc;
  wire [4:0] assign_bits;

  // Reserved ignored
  // [R12] bits 4..6, 9, 10 unused
  assign cmd_rdata = drive_command_word_reg;
  assign cmd_so = drive_command_word_reg[`DCW_BIT_SWITCH_ON];
  assign cmd_ev = drive_command_word_reg[`DCW_BIT_ENABLE_VOLTAGE];
  assign cmd_qs = drive_command_word_reg[`DCW_BIT_QUICK_STOP];
  assign cmd_eo = drive_command_word_reg[`DCW_BIT_ENABLE_OP];
  assign assign_bits = drive_command_word_reg[`DCW_ASSIGN_MSB:`DCW_ASSIGN_LSB];
  // [R08] rising edge detect
  assign fault_reset_edge = drive_command_word_reg[`DCW_BIT_FAULT_RESET] & ~fault_reset_prev_reg;

  // [R06] assignable bit sources
  dcw_bit_select u_sel_dir (.src_sel(dir_src), .assign_bits(assign_bits), .fallback(term_dir), .func_out(sel_dir));
  dcw_bit_select u_sel_fast (.src_sel(fast_stop_src), .assign_bits(assign_bits), .fallback(1'b0),
    .func_out(sel_fast));
  dcw_bit_select u_sel_free (.src_sel(freewheel_src), .assign_bits(assign_bits), .fallback(1'b0),
    .func_out(sel_free));
  dcw_bit_select u_sel_dc (.src_sel(dc_inj_src), .assign_bits(assign_bits), .fallback(1'b0), .func_out(sel_dc));

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      drive_command_word_reg <= `DCW_CMD_RESET;
      fault_reset_prev_reg <= 1'b0;
    end else begin
      if (cmd_we) begin
        drive_command_word_reg <= cmd_wdata;
      end
      fault_reset_prev_reg <= drive_command_word_reg[`DCW_BIT_FAULT_RESET];
    end
  end

  // State transitions
  always @* begin
    op_state_next = op_state_reg;
    stopping_next = 1'b0;
    if (fault_detect && op_state_reg != `DCW_ST_FAULT_REACT && op_state_reg != `DCW_ST_FAULT) begin
      op_state_next = `DCW_ST_FAULT_REACT;
    end else begin
      case (op_state_reg)
        `DCW_ST_NOT_READY: begin
          if (power_ready) begin
            op_state_next = `DCW_ST_SW_ON_DIS;
          end
        end
        `DCW_ST_SW_ON_DIS: begin
          // [R09] don't-care bits ignored
          if (cmd_ev && cmd_qs && !term_freewheel && !sel_free) begin
            op_state_next = (cmd_so && cmd_eo) ? `DCW_ST_OP_ENABLED : `DCW_ST_READY;
          end
        end
        `DCW_ST_READY, `DCW_ST_SWITCHED_ON: begin
          if (!cmd_ev || term_freewheel || sel_free) begin
            op_state_next = `DCW_ST_SW_ON_DIS;
          end else if (!cmd_qs) begin
            op_state_next = `DCW_ST_SW_ON_DIS;
          end else if (!cmd_so) begin
            op_state_next = `DCW_ST_READY;
          end else if (cmd_eo && !term_fast_stop && !sel_fast) begin
            op_state_next = `DCW_ST_OP_ENABLED;
          end else begin
            op_state_next = `DCW_ST_SWITCHED_ON;
          end
        end
        `DCW_ST_OP_ENABLED: begin
          // [R05] freewheel stop
          if (!cmd_ev || term_freewheel || sel_free) begin
            op_state_next = `DCW_ST_SW_ON_DIS;
          end else if (!cmd_qs) begin
            op_state_next = `DCW_ST_QSTOP;
          end else if (!cmd_so) begin
            op_state_next = `DCW_ST_READY;
          // [R04] fast stop to 4
          end else if (term_fast_stop || sel_fast) begin
            op_state_next = `DCW_ST_SWITCHED_ON;
          // [R13] disable operation stop
          end else if (!cmd_eo) begin
            if (disable_op_ramp && !(stopping_reg && ramp_done)) begin
              stopping_next = 1'b1;
            end else begin
              op_state_next = `DCW_ST_SWITCHED_ON;
            end
          end
        end
        `DCW_ST_QSTOP: begin
          if (!cmd_ev || term_freewheel || sel_free) begin
            op_state_next = `DCW_ST_SW_ON_DIS;
          end else if (ramp_done && !quick_stop_behaviour_select) begin
            op_state_next = `DCW_ST_SW_ON_DIS;
          end
        end
        `DCW_ST_FAULT_REACT: begin
          if (fault_react_done) begin
            op_state_next = `DCW_ST_FAULT;
          end
        end
        `DCW_ST_FAULT: begin
          // [R08] reset once cause gone
          if (fault_reset_edge && !fault_active) begin
            op_state_next = `DCW_ST_SW_ON_DIS;
          end
        end
        default: begin
          op_state_next = `DCW_ST_NOT_READY;
        end
      endcase
    end
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      op_state_reg <= `DCW_ST_NOT_READY;
      stopping_reg <= 1'b0;
      motor_energised_reg <= 1'b0;
      supply_required_reg <= 1'b0;
      dir_reverse_reg <= 1'b0;
      dc_inj_req_reg <= 1'b0;
      halt_stop_mode_reg <= `DCW_STOP_RAMP;
      halt_active_reg <= 1'b0;
      ramp_active_reg <= 1'b0;
      freewheel_active_reg <= 1'b0;
    end else begin
      op_state_reg <= op_state_next;
      stopping_reg <= stopping_next;
      // [R07] direction from bit 11
      dir_reverse_reg <= sel_dir;
      dc_inj_req_reg <= sel_dc;
      halt_stop_mode_reg <= stop_type;
      // [R01] [R03] halt stays in state 5
      halt_active_reg <= (op_state_next == `DCW_ST_OP_ENABLED) && drive_command_word_reg[`DCW_BIT_HALT];
      ramp_active_reg <= stopping_next || (op_state_next == `DCW_ST_QSTOP);
      freewheel_active_reg <= (op_state_reg == `DCW_ST_OP_ENABLED) && (op_state_next == `DCW_ST_SWITCHED_ON)
        && !disable_op_ramp;
      case (op_state_next)
        `DCW_ST_OP_ENABLED: begin
          // [R02] no torque during halt
          motor_energised_reg <= !drive_command_word_reg[`DCW_BIT_HALT];
          supply_required_reg <= 1'b1;
        end
        `DCW_ST_QSTOP: begin
          motor_energised_reg <= !ramp_done;
          supply_required_reg <= 1'b1;
        end
        `DCW_ST_SWITCHED_ON: begin
          motor_energised_reg <= 1'b0;
          supply_required_reg <= 1'b1;
        end
        `DCW_ST_FAULT_REACT: begin
          // [R10] follow error response
          motor_energised_reg <= err_resp_energise;
          supply_required_reg <= err_resp_supply;
        end
        default: begin
          motor_energised_reg <= 1'b0;
          supply_required_reg <= 1'b0;
        end
      endcase
    end
  end

  // State word, masked codes plus voltage, remote and direction
  // [R14] masked codes
  always @* begin
    case (op_state_reg)
      `DCW_ST_SW_ON_DIS: sw_code = `DCW_SW_SW_ON_DIS;
      `DCW_ST_READY: sw_code = `DCW_SW_READY;
      `DCW_ST_SWITCHED_ON: sw_code = `DCW_SW_SWITCHED_ON;
      `DCW_ST_OP_ENABLED: sw_code = `DCW_SW_OP_ENABLED;
      `DCW_ST_QSTOP: sw_code = `DCW_SW_QSTOP;
      `DCW_ST_FAULT_REACT: sw_code = `DCW_SW_FAULT_REACT;
      `DCW_ST_FAULT: sw_code = `DCW_SW_FAULT;
      default: sw_code = `DCW_SW_NOT_READY;
    endcase
  end
  assign drive_state_word = {dir_reverse_reg, 5'h00, 1'b1, 1'b0, 3'h0, supply_present, sw_code[3:0]} |
    {8'h00, 1'b0, sw_code[6:5], 5'h00};
endmodule

// ---- test/dcw_master.sv ----
// Fieldbus master model: writes the command word, one strobe per write.
// Drives on the rising edge of core_clk; the data bus carries the inverted word after each write.
`timescale 1ns/1ps
module dcw_master (
  // Clock
  input wire core_clk,
  // Command word write
  output logic cmd_we,
  output logic [15:0] cmd_wdata
);
  initial begin
    cmd_we = 1'b0;
    cmd_wdata = 16'h0000;
  end
  function automatic logic [15:0] code(input int c);
    case (c)
      0: return 16'h0006;
      1: return 16'h0007;
      2: return 16'h000F;
      3: return 16'h0000;
      default: return 16'h0002;
    endcase
  endfunction
  task wr(input logic [15:0] w);
    @(posedge core_clk) begin
      cmd_we <= 1'b1;
      cmd_wdata <= w;
    end
    @(posedge core_clk) begin
      cmd_we <= 1'b0;
      cmd_wdata <= ~w;
    end
  endtask
endmodule

// ---- test/dcw_chk.sv ----
// Port checker for the command word interpreter.
// Bound to dcw_interpreter; single clock domain.
`timescale 1ns/1ps
module dcw_chk (
  // Clock and reset
  input wire core_clk,
  input wire rst_n,
  // Watched ports
  input wire [15:0] cmd_rdata,
  input wire [1:0] stop_type,
  input wire err_resp_supply,
  input wire err_resp_energise,
  input wire [2:0] dir_src,
  input wire term_fast_stop,
  input wire term_freewheel,
  input wire fault_detect,
  input wire fault_active,
  input wire [3:0] op_state_reg,
  input wire motor_energised_reg,
  input wire supply_required_reg,
  input wire dir_reverse_reg,
  input wire [1:0] halt_stop_mode_reg,
  input wire halt_active_reg
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  wire fw_cond = term_freewheel && !fault_detect && op_state_reg >= 4'h3 && op_state_reg <= 4'h5;
  wire fs_cond = term_fast_stop && !term_freewheel && !fault_detect && op_state_reg == 4'h5 && cmd_rdata[2:0] == 3'h7;
  a_halt_keeps_state: assert property (halt_active_reg |-> op_state_reg == 4'h5)
    else $error("halt outside state 5");
  a_halt_no_torque: assert property (halt_active_reg |-> !motor_energised_reg)
    else $error("motor powered in halt");
  a_halt_stop_mode: assert property (rst_n |=> halt_stop_mode_reg == $past(stop_type))
    else $error("halt stop mode mismatch");
  a_dir_from_bit: assert property ($past(dir_src) == 3'h1 |-> dir_reverse_reg == $past(cmd_rdata[11]))
    else $error("direction not bit 11");
  a_fault_exit: assert property ($past(op_state_reg) == 4'h8 && op_state_reg != 4'h8
    |-> op_state_reg == 4'h2 && $past(cmd_rdata[7]) && !$past(fault_active))
    else $error("bad fault exit");
  a_fault_react_out: assert property (op_state_reg == 4'h7
    |-> motor_energised_reg == $past(err_resp_energise) && supply_required_reg == $past(err_resp_supply))
    else $error("fault reaction outputs");
  a_freewheel_off: assert property ($past(fw_cond) |-> op_state_reg == 4'h2)
    else $error("freewheel not to state 2");
  a_fast_stop_on: assert property ($past(fs_cond) |-> op_state_reg == 4'h4)
    else $error("fast stop not to state 4");
endmodule
bind dcw_interpreter dcw_chk u_chk (
  .core_clk(core_clk),
  .rst_n(rst_n),
  .cmd_rdata(cmd_rdata),
  .stop_type(stop_type),
  .err_resp_supply(err_resp_supply),
  .err_resp_energise(err_resp_energise),
  .dir_src(dir_src),
  .term_fast_stop(term_fast_stop),
  .term_freewheel(term_freewheel),
  .fault_detect(fault_detect),
  .fault_active(fault_active),
  .op_state_reg(op_state_reg),
  .motor_energised_reg(motor_energised_reg),
  .supply_required_reg(supply_required_reg),
  .dir_reverse_reg(dir_reverse_reg),
  .halt_stop_mode_reg(halt_stop_mode_reg),
  .halt_active_reg(halt_active_reg)
);

// ---- test/testbench.sv ----
// Self-checking bench for dcw_interpreter with a fieldbus master model.
// Expects dcw_master and the bound checker to be compiled first.
`timescale 1ns/1ps
module testbench;
  logic core_clk = 0, rst_n = 0, disable_op_ramp = 0, quick_stop_behaviour_select = 1;
  logic err_resp_supply = 1, err_resp_energise = 0, term_fast_stop = 0, term_freewheel = 0, term_dir = 0;
  logic power_ready = 0, fault_detect = 0, fault_active = 0, fault_react_done = 0, ramp_done = 0;
  logic supply_present = 0;
  logic [1:0] stop_type = 0;
  logic [2:0] dir_src = 1, fast_stop_src = 0, freewheel_src = 0, dc_inj_src = 3;
  wire cmd_we, motor_energised_reg, supply_required_reg, dir_reverse_reg, dc_inj_req_reg;
  wire halt_active_reg, ramp_active_reg, freewheel_active_reg;
  wire [15:0] cmd_wdata, cmd_rdata, drive_state_word;
  wire [3:0] op_state_reg;
  wire [1:0] halt_stop_mode_reg;
  int miscompares = 0, compares = 0, s, i, k;
  logic [15:0] r = 16'h0245, w;
  logic [15:0] sw [0:8] = '{16'h0000, 16'h0000, 16'h0040, 16'h0021, 16'h0023, 16'h0027, 16'h0007, 16'h000F, 16'h0008};
  dcw_master M (.core_clk(core_clk), .cmd_we(cmd_we), .cmd_wdata(cmd_wdata));
  dcw_interpreter DUT (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .cmd_we(cmd_we),
    .cmd_wdata(cmd_wdata),
    .cmd_rdata(cmd_rdata),
    .stop_type(stop_type),
    .disable_op_ramp(disable_op_ramp),
    .quick_stop_behaviour_select(quick_stop_behaviour_select),
    .err_resp_supply(err_resp_supply),
    .err_resp_energise(err_resp_energise),
    .dir_src(dir_src),
    .fast_stop_src(fast_stop_src),
    .freewheel_src(freewheel_src),
    .dc_inj_src(dc_inj_src),
    .term_fast_stop(term_fast_stop),
    .term_freewheel(term_freewheel),
    .term_dir(term_dir),
    .power_ready(power_ready),
    .fault_detect(fault_detect),
    .fault_active(fault_active),
    .fault_react_done(fault_react_done),
    .ramp_done(ramp_done),
    .supply_present(supply_present),
    .op_state_reg(op_state_reg),
    .drive_state_word(drive_state_word),
    .motor_energised_reg(motor_energised_reg),
    .supply_required_reg(supply_required_reg),
    .dir_reverse_reg(dir_reverse_reg),
    .dc_inj_req_reg(dc_inj_req_reg),
    .halt_stop_mode_reg(halt_stop_mode_reg),
    .halt_active_reg(halt_active_reg),
    .ramp_active_reg(ramp_active_reg),
    .freewheel_active_reg(freewheel_active_reg)
  );
  initial forever #12.5 core_clk = ~core_clk;
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  function automatic int mdl(int st, logic [15:0] c);
    if (st == 6) return c[1] ? 6 : 2;
    if (st < 2 || st > 5) return st;
    if (!c[1]) return 2;
    if (!c[2]) return st == 5 ? 6 : 2;
    if (!c[0]) return 3;
    return c[3] ? 5 : (st == 2 ? 2 : 4);
  endfunction
  task conclude;
    $display("miscompares=%0d compares=%0d", miscompares, compares);
    if (miscompares == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task chk(input logic ok, input string m);
    compares++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  task settle;
    repeat (2) @(posedge core_clk);
    #1;
  endtask
  task step(input logic [15:0] c);
    M.wr(c);
    settle;
  endtask
  task to5;
    step(16'h0000);
    step(16'h0006);
    step(16'h000F);
  endtask
  initial begin
    #200000;
    miscompares++;
    conclude;
  end
  initial begin
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    #1 chk(op_state_reg === 4'h1 && cmd_rdata === 16'h0000 && drive_state_word === 16'h0200, "reset");
    @(posedge core_clk) power_ready <= 1'b1;
    settle;
    s = 2;
    for (i = 0; i < 60; i++) begin
      r = lfsr(r);
      w = M.code(r % 5) | (r & 16'hFE70);
      if (s == 2 && w[3:0] == 4'h7) w[0] = 1'b0;
      @(posedge core_clk) supply_present <= r[0];
      step(w);
      s = mdl(s, w);
      chk(op_state_reg === s[3:0] && (drive_state_word & 16'h006F) === sw[s], "state");
      chk(dir_reverse_reg === w[11] && drive_state_word[4] === r[0], "dir or supply");
      chk(cmd_rdata === w && dc_inj_req_reg === w[13], "readback or dc bit");
      chk(motor_energised_reg === (s == 5 || s == 6), "motor power");
      chk(supply_required_reg === (s >= 4 && s <= 6), "supply need");
    end
    for (k = 0; k < 4; k++) begin
      @(posedge core_clk) stop_type <= k[1:0];
      to5;
      step(16'h010F);
      chk(op_state_reg === 4'h5 && halt_active_reg === 1'b1 && halt_stop_mode_reg === k[1:0], "halt");
      chk(motor_energised_reg === 1'b0, "torque in halt");
      step(16'h000F);
      chk(motor_energised_reg === 1'b1 && halt_active_reg === 1'b0, "resume");
    end
    // Freewheel flag stands for the one cycle of the 5 to 4 step
    M.wr(16'h0007);
    @(posedge core_clk);
    #1 chk(op_state_reg === 4'h4 && freewheel_active_reg === 1'b1, "freewheel disable");
    @(posedge core_clk) disable_op_ramp <= 1'b1;
    step(16'h000F);
    step(16'h0007);
    chk(op_state_reg === 4'h5 && ramp_active_reg === 1'b1, "ramping");
    @(posedge core_clk) ramp_done <= 1'b1;
    settle;
    chk(op_state_reg === 4'h4 && ramp_active_reg === 1'b0 && freewheel_active_reg === 1'b0, "ramp end");
    @(posedge core_clk) begin
      ramp_done <= 1'b0;
      term_fast_stop <= 1'b1;
    end
    step(16'h000F);
    chk(op_state_reg === 4'h4, "fast stop blocks");
    @(posedge core_clk) begin
      term_fast_stop <= 1'b0;
      fast_stop_src <= 3'h2;
    end
    step(16'h000F);
    step(16'h100F);
    chk(op_state_reg === 4'h4, "fast stop bit");
    step(16'h000F);
    @(posedge core_clk) term_fast_stop <= 1'b1;
    settle;
    chk(op_state_reg === 4'h4, "fast stop terminal");
    @(posedge core_clk) begin
      term_fast_stop <= 1'b0;
      freewheel_src <= 3'h5;
    end
    step(16'h000F);
    step(16'h800F);
    chk(op_state_reg === 4'h2, "freewheel bit");
    step(16'h000F);
    @(posedge core_clk) term_freewheel <= 1'b1;
    settle;
    chk(op_state_reg === 4'h2, "freewheel terminal");
    @(posedge core_clk) begin
      err_resp_energise <= 1'b1;
      err_resp_supply <= 1'b0;
      freewheel_src <= 3'h0;
      term_freewheel <= 1'b0;
    end
    to5;
    @(posedge core_clk) begin
      fault_detect <= 1'b1;
      fault_active <= 1'b1;
    end
    @(posedge core_clk) fault_detect <= 1'b0;
    #1 chk(op_state_reg === 4'h7, "fault reaction");
    chk(motor_energised_reg === 1'b1 && supply_required_reg === 1'b0, "fault outputs");
    @(posedge core_clk) fault_react_done <= 1'b1;
    step(16'h0000);
    step(16'h0080);
    chk(op_state_reg === 4'h8, "cause present");
    @(posedge core_clk) fault_active <= 1'b0;
    step(16'h0080);
    chk(op_state_reg === 4'h8, "no edge");
    step(16'h0000);
    step(16'h0080);
    chk(op_state_reg === 4'h2, "fault cleared");
    conclude;
  end
endmodule
